// File: hdl/tag_store_flush_error_capture.sv
// Tag controller maintenance: error address capture, flushes and invalidate filtering.
`timescale 1ns/1ps
`include "tag_maint_regs.svh"
module tag_store_flush_error_capture (
	// Clock and reset.
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	// Processor register port.
	input  wire tag_maint_pkg::proc_reg_req_s  preg_req,
	output tag_maint_pkg::proc_reg_rsp_s       preg_rsp,
	// Control bits.
	input  wire logic                          backup_tags_on_set,
	input  wire logic                          primary_copy_on_set,
	output logic                               backup_tags_on,
	output logic                               primary_copy_on,
	// Error reporting.
	input  wire logic                          status_load,
	input  wire logic                          status_lock_clear,
	input  wire logic                          err_is_primary_copy,
	input  wire logic                          cur_is_inv,
	input  wire logic [29:0]                   cur_addr,
	output logic                               status_lock,
	// Cache traffic.
	input  wire logic                          cacheable_read,
	input  wire logic [29:0]                   read_addr,
	input  wire logic                          backup_fill,
	input  wire tag_maint_pkg::inv_req_s       inv_req,
	output tag_maint_pkg::inv_out_s            local_inv,
	output logic                               backup_inv_hit
);
	import tag_maint_pkg::*;

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		logic          lock;
		logic          bk_on;
		logic          pc_on;
		logic [26:0]   err_addr;
		proc_reg_rsp_s rsp;
		inv_out_s      inv;
		logic          bk_hit;
	} top_state_s;
	top_state_s st_r;
	top_state_s st_nxt;

	logic flush_bk;
	logic flush_pc;
	logic pc_valid;
	logic bk_valid;
	logic [`PRIMARY_IDX_BITS-1:0] rd_idx;
	logic [`PRIMARY_IDX_BITS-1:0] inv_idx;

	// Flush fires on the write alone; the data bus is never looked at.
	assign flush_bk = preg_req.valid && preg_req.write
		&& preg_req.regnum == `REG_FLUSH_BACKUP;
	assign flush_pc = preg_req.valid && preg_req.write
		&& preg_req.regnum == `REG_FLUSH_PRIMARY;
	assign rd_idx  = read_addr[`INV_ADDR_LO +: `PRIMARY_IDX_BITS];
	assign inv_idx = inv_req.addr[`PRIMARY_IDX_BITS-1:0];

	// ****************************************************************
	// Valid bit banks.
	// ****************************************************************
	valid_bank #(.IDX_BITS(`PRIMARY_IDX_BITS)) u_primary_copy (
		.clk        (clk),
		.reset_n    (reset_n),
		.flush      (flush_pc),
		.set_en     (cacheable_read),
		.set_idx    (rd_idx),
		.look_idx   (inv_idx),
		.look_valid (pc_valid)
	);
	// Fills are suppressed while the backup store is off.
	valid_bank #(.IDX_BITS(`BACKUP_IDX_BITS)) u_backup (
		.clk        (clk),
		.reset_n    (reset_n),
		.flush      (flush_bk),
		.set_en     (backup_fill && st_r.bk_on),
		.set_idx    (rd_idx),
		.look_idx   (inv_idx),
		.look_valid (bk_valid)
	);

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp.done  = preg_req.valid;
		st_nxt.rsp.rdata = `RESET_ZERO_32;
		if (preg_req.valid && !preg_req.write && preg_req.regnum == `REG_ERR_ADDR) begin
			st_nxt.rsp.rdata[`ERR_ADDR_HI:`ERR_ADDR_LO] = st_r.err_addr;
		end
		// Enables only ever set here; reset is the sole clear.
		if (backup_tags_on_set) begin
			st_nxt.bk_on = 1'b1;
		end
		if (primary_copy_on_set) begin
			st_nxt.pc_on = 1'b1;
		end
		// Errors from a disabled copy neither capture nor lock.
		// A clear in the cycle of a new error frees the lock for that error, so set wins.
		if (status_load && !(err_is_primary_copy && !st_r.pc_on)
			&& (!st_r.lock || status_lock_clear)) begin
			// Capture is on the status load alone; a late bus error may find a newer address.
			st_nxt.lock = 1'b1;
			if (cur_is_inv) begin
				st_nxt.err_addr = {1'b0, cur_addr[`INV_ADDR_HI:`INV_ADDR_LO], 1'b0};
			end else begin
				st_nxt.err_addr = cur_addr[`ERR_ADDR_HI:`ERR_ADDR_LO];
			end
		end else if (status_lock_clear) begin
			st_nxt.lock = 1'b0;
		end
		// Invalidates go out only on a hit in an enabled copy.
		st_nxt.inv.valid = inv_req.valid && st_r.pc_on && pc_valid;
		st_nxt.inv.addr  = {1'b0, inv_req.addr, 1'b0};
		st_nxt.bk_hit    = inv_req.valid && st_r.bk_on && bk_valid;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign preg_rsp        = st_r.rsp;
	assign backup_tags_on  = st_r.bk_on;
	assign primary_copy_on = st_r.pc_on;
	assign status_lock     = st_r.lock;
	assign local_inv       = st_r.inv;
	assign backup_inv_hit  = st_r.bk_hit;
endmodule

// File: hdl/valid_bank.sv
// One bank of tag valid bits with flush, set and lookup.
`timescale 1ns/1ps
module valid_bank #(
	parameter int IDX_BITS = 4
) (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Updates.
	input  wire logic                flush,
	input  wire logic                set_en,
	input  wire logic [IDX_BITS-1:0] set_idx,
	// Lookup.
	input  wire logic [IDX_BITS-1:0] look_idx,
	output logic                     look_valid
);
	typedef struct packed {
		logic [(1<<IDX_BITS)-1:0] bits;
	} bank_state_s;
	bank_state_s st_r;
	bank_state_s st_nxt;
	always_comb begin
		st_nxt = st_r;
		// Set comes after flush so a fill in the flush cycle survives.
		if (flush) begin
			st_nxt.bits = '0;
		end
		if (set_en) begin
			st_nxt.bits[set_idx] = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign look_valid = st_r.bits[look_idx];
endmodule

// File: pkg/tag_maint_pkg.sv
// Types shared by the tag maintenance block.
package tag_maint_pkg;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  regnum;
		logic [31:0] wdata;
	} proc_reg_req_s;
	typedef struct packed {
		logic        done;
		logic [31:0] rdata;
	} proc_reg_rsp_s;
	typedef struct packed {
		logic        valid;
		logic [24:0] addr;
	} inv_req_s;
	typedef struct packed {
		logic        valid;
		logic [26:0] addr;
	} inv_out_s;
endpackage

// File: pkg/tag_maint_regs.svh
// Register numbers, field positions, reset values and sizes for the tag maintenance block.
`ifndef TAG_MAINT_REGS_SVH
`define TAG_MAINT_REGS_SVH
`define REG_ERR_ADDR      8'h78
`define REG_FLUSH_BACKUP  8'h79
`define REG_FLUSH_PRIMARY 8'h7A
`define ERR_ADDR_HI       29
`define ERR_ADDR_LO       3
`define INV_ADDR_HI       28
`define INV_ADDR_LO       4
`define BACKUP_IDX_BITS   4
`define PRIMARY_IDX_BITS  4
`define RESET_ZERO_32     32'h0000_0000
`define FLUSH_CYCLES      1
`endif

// File: tb/cpu_model.sv
// CPU side model issuing processor register reads and writes.
`timescale 1ns/1ps
module cpu_model import tag_maint_pkg::*; (
	input  wire logic          clk,
	input  wire proc_reg_rsp_s rsp,
	output proc_reg_req_s      req
);
	logic got;
	initial req = '0;
	// Only single move requests reach the block; released data shows its inverse.
	// Index, tag-entry and control writes go to other blocks.
	// An idle edge follows each request so back-to-back calls never drive twice at once.
	task automatic op(input logic w, input logic [7:0] n, input logic [31:0] d,
		output logic [31:0] rd);
		req = '{1'h1, w, n, d};
		@(posedge clk);
		#1;
		req = '{1'h0, 1'h0, 8'h00, ~d};
		rd = rsp.rdata;
		got = rsp.done;
		@(posedge clk);
		#1;
	endtask
endmodule

// File: tb/tag_maint_checker.sv
// Port assertions for the tag maintenance block.
`timescale 1ns/1ps
module tag_maint_checker import tag_maint_pkg::*; (
	input wire logic clk, reset_n, backup_tags_on_set, primary_copy_on_set,
	input wire proc_reg_req_s preg_req,
	input wire proc_reg_rsp_s preg_rsp,
	input wire logic backup_tags_on, primary_copy_on, status_load, status_lock_clear,
	input wire logic err_is_primary_copy, cur_is_inv, status_lock, cacheable_read,
	input wire logic [29:0] cur_addr, read_addr,
	input wire logic backup_fill, backup_inv_hit,
	input wire inv_req_s inv_req,
	input wire inv_out_s local_inv
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_done_follows: assert property (preg_req.valid |=> preg_rsp.done)
		else $error("no done");
	a_mbz_bits: assert property (preg_rsp.done |-> preg_rsp.rdata[31:30] == 2'h0
		&& preg_rsp.rdata[2:0] == 3'h0) else $error("mbz set");
	a_lock_set: assert property (status_load && !err_is_primary_copy |=> status_lock)
		else $error("no lock");
	a_lock_hold: assert property (status_lock && !status_lock_clear |=> status_lock)
		else $error("lock lost");
	a_copy_err_quiet: assert property (status_load && err_is_primary_copy
		&& !primary_copy_on && !status_lock |=> !status_lock) else $error("copy error locked");
	a_copy_sticky: assert property (primary_copy_on |=> primary_copy_on)
		else $error("copy enable dropped");
	a_copy_quiet: assert property (!primary_copy_on |=> !local_inv.valid)
		else $error("hit while off");
	a_backup_quiet: assert property (!backup_tags_on |=> !backup_inv_hit)
		else $error("backup hit while off");
	a_inv_map: assert property (local_inv.valid |-> $past(inv_req.valid)
		&& local_inv.addr == {1'h0, $past(inv_req.addr), 1'h0}) else $error("bad inv");
	a_flush_copy: assert property (preg_req.valid && preg_req.write && !cacheable_read
		&& preg_req.regnum == 8'h7A ##1 inv_req.valid |=> !local_inv.valid)
		else $error("copy not flushed");
	a_flush_backup: assert property (preg_req.valid && preg_req.write && !backup_fill
		&& preg_req.regnum == 8'h79 ##1 inv_req.valid |=> !backup_inv_hit)
		else $error("backup not flushed");
	cover property (local_inv.valid && backup_inv_hit);
	cover property (status_load && status_lock);
	cover property (preg_req.valid && preg_req.write && preg_req.regnum == 8'h78);
endmodule
bind tag_store_flush_error_capture tag_maint_checker chk_i (.*);

// File: tb/tag_store_flush_error_capture_tb.sv
// Self-checking bench for the tag maintenance block.
`timescale 1ns/1ps
module tag_store_flush_error_capture_tb;
	import tag_maint_pkg::*;
	logic clk = 1'h0, reset_n = 1'h0, bset = 1'h0, pset = 1'h0, sload = 1'h0, sclr = 1'h0;
	logic isinv = 1'h0, cread = 1'h0, bfill = 1'h0, ecopy = 1'h0, bon, pon, lock, bhit;
	logic [29:0] caddr = '0, raddr = 30'h0000_0050;
	logic [31:0] rd;
	inv_req_s inv = '0;
	proc_reg_req_s req;
	proc_reg_rsp_s rsp;
	inv_out_s linv;
	int fails = 0, checks_done = 0, cyc = 0;
	always #10 clk = ~clk;
	tag_store_flush_error_capture DUT (.clk(clk), .reset_n(reset_n), .preg_req(req),
		.preg_rsp(rsp), .backup_tags_on_set(bset), .primary_copy_on_set(pset),
		.backup_tags_on(bon), .primary_copy_on(pon), .status_load(sload),
		.status_lock_clear(sclr), .err_is_primary_copy(ecopy), .cur_is_inv(isinv),
		.cur_addr(caddr), .status_lock(lock), .cacheable_read(cread), .read_addr(raddr),
		.backup_fill(bfill), .inv_req(inv), .local_inv(linv), .backup_inv_hit(bhit));
	cpu_model cpu (.clk(clk), .rsp(rsp), .req(req));
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	task load(input logic i, input logic [29:0] a);
		isinv = i;
		caddr = a;
		sload = 1'h1;
		step;
		sload = 1'h0;
	endtask
	task unlock;
		sclr = 1'h1;
		step;
		sclr = 1'h0;
	endtask
	task probe(input logic el, input logic eb);
		inv = '{1'h1, 25'h0000005};
		step;
		inv = '{1'h0, 25'h1FFFFFA};
		chk(linv.valid, el);
		if (el) chk(linv.addr, 27'h000000A);
		chk(bhit, eb);
	endtask
	task t_err;
		ecopy = 1'h1;
		load(1'h0, 30'h0000_0FF8);
		ecopy = 1'h0;
		chk(lock, 1'h0);
		load(1'h0, 30'h2ABC_DEFF);
		chk(lock, 1'h1);
		cpu.op(1'h0, 8'h78, '0, rd);
		chk(rd, 32'h2ABC_DEF8);
		load(1'h0, 30'h0000_1238);
		cpu.op(1'h1, 8'h78, 32'hFFFF_FFFF, rd);
		chk(cpu.got, 1'h1);
		cpu.op(1'h0, 8'h78, '0, rd);
		chk(rd, 32'h2ABC_DEF8);
		unlock;
		load(1'h1, 30'h3FFF_FFFF);
		cpu.op(1'h0, 8'h78, '0, rd);
		chk(rd, 32'h1FFF_FFF0);
		sclr = 1'h1;
		load(1'h0, 30'h0000_1238);
		sclr = 1'h0;
		chk(lock, 1'h1);
		cpu.op(1'h0, 8'h78, '0, rd);
		chk(rd, 32'h0000_1238);
		unlock;
		$display("t_err done");
	endtask
	task t_cache;
		cread = 1'h1;
		step;
		cread = 1'h0;
		probe(1'h0, 1'h0);
		bset = 1'h1;
		pset = 1'h1;
		step;
		{bset, pset, bfill} = 3'h1;
		step;
		bfill = 1'h0;
		probe(1'h1, 1'h1);
		cpu.op(1'h1, 8'h7A, 32'hFFFF_FFFF, rd);
		probe(1'h0, 1'h1);
		cpu.op(1'h0, 8'h7A, '0, rd);
		chk(cpu.got, 1'h1);
		cpu.op(1'h1, 8'h79, '0, rd);
		probe(1'h0, 1'h0);
		chk({bon, pon}, 2'h3);
		reset_n = 1'h0;
		step;
		reset_n = 1'h1;
		chk({bon, pon, lock}, 3'h0);
		$display("t_cache done");
	endtask
	task report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 reset_n = 1'h1;
		t_err;
		t_cache;
		report_and_stop;
	end
	// The tests need under fifty cycles, so this ceiling only catches a hang.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			report_and_stop;
		end
	end
endmodule
